/* pcic_port.sv */
// pcic_port: port configuration, negotiation steering and interface counters, ahb-lite slave
`timescale 1ns/1ps
`default_nettype none

module pcic_port
   import pcic_pkg::*;
#(
   parameter int CNT_W = 32,
   parameter int OCT_W = 16
) (
   input  wire logic               clock,
   input  wire logic               reset_n,
   // ahb-lite slave
   input  wire logic               hsel,
   input  wire logic [31:0]        haddr,
   input  wire logic [1:0]         htrans,
   input  wire logic               hwrite,
   input  wire logic [2:0]         hsize,
   input  wire logic               hready,
   input  wire logic [31:0]        hwdata,
   output logic      [31:0]        hrdata,
   output logic                    hreadyout,
   output logic                    hresp,
   // phy pins, asynchronous to clock
   input  wire logic               phy_link_up,
   input  wire logic               phy_an_done,
   input  wire logic               phy_lp_pause,
   input  wire logic [1:0]         phy_rate,
   input  wire logic               phy_full,
   // phy control
   output logic                    phy_enable,
   output logic                    phy_an_enable,
   output logic                    phy_adv_10,
   output logic                    phy_adv_100,
   output logic                    phy_adv_1000,
   output logic                    phy_adv_half,
   output logic                    phy_adv_full,
   output logic                    phy_adv_pause,
   output logic [1:0]              phy_force_rate,
   output logic                    phy_force_full,
   // mac pause control
   output logic                    mac_rx_pause_en,
   output logic                    mac_tx_pause_en,
   // mac statistics events, same clock
   input  wire logic               rx_frame_ev,
   input  wire logic [OCT_W-1:0]   rx_frame_octets,
   input  wire logic               rx_ucast_ev,
   input  wire logic               rx_unknown_ev,
   input  wire logic               rx_discard_ev,
   input  wire logic               rx_mcast_ev,
   input  wire logic               rx_bcast_ev,
   input  wire logic               tx_frame_ev,
   input  wire logic [OCT_W-1:0]   tx_frame_octets,
   input  wire logic               tx_ucast_req,
   input  wire logic               tx_unknown_req,
   input  wire logic               tx_discard_ev,
   input  wire logic               tx_mcast_req,
   input  wire logic               tx_bcast_req
);
   import pcic_pkg::*;

   // ------------------------------------------------------------
   // elaboration checks
   // ------------------------------------------------------------
   if (CNT_W < 1 || CNT_W > 32) begin : g_bad_cnt
      $error("CNT_W must be 1..32");
   end
   if (OCT_W < 1 || OCT_W > CNT_W) begin : g_bad_oct
      $error("OCT_W must be 1..CNT_W");
   end

   // ------------------------------------------------------------
   // pin synchronisers
   // ------------------------------------------------------------
   localparam int PIN_W = 6;
   logic [PIN_W-1:0] pin_raw;
   logic [PIN_W-1:0] pin_s1_q;
   logic [PIN_W-1:0] pin_s2_q;
   logic [PIN_W-1:0] pin_s3_q;
   logic [PIN_W-1:0] pin_q;
   logic [PIN_W-1:0] pin_d;

   assign pin_raw = {phy_full, phy_rate, phy_lp_pause, phy_an_done, phy_link_up};

   // a bit moves only once the second and third stages agree, filtering one-cycle glitches
   genvar gp;
   generate
      for (gp = 0; gp < PIN_W; gp++) begin : g_pin
         assign pin_d[gp] = (pin_s2_q[gp] == pin_s3_q[gp]) ? pin_s3_q[gp] : pin_q[gp];
      end
   endgenerate

   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         pin_s1_q <= '0;
         pin_s2_q <= '0;
         pin_s3_q <= '0;
         pin_q    <= '0;
      end else begin
         pin_s1_q <= pin_raw;
         pin_s2_q <= pin_s1_q;
         pin_s3_q <= pin_s2_q;
         pin_q    <= pin_d;
      end
   end

   wire       link_up  = pin_q[0];
   wire       an_done  = pin_q[1];
   wire       lp_pause = pin_q[2];
   wire [1:0] lp_rate  = pin_q[4:3];
   wire       lp_full  = pin_q[5];

   // ------------------------------------------------------------
   // ahb-lite slave
   // ------------------------------------------------------------
   logic [6:0]  ctrl_q;
   logic [6:0]  ctrl_d;
   logic        wr_pend_q;
   logic [7:0]  wr_addr_q;
   logic [31:0] hrdata_q;
   logic [31:0] rd_mux;

   wire addr_phase = hsel && hready && (htrans == PCIC_HTRANS_NONSEQ);
   wire rd_take    = addr_phase && !hwrite;
   wire wr_take    = addr_phase && hwrite;
   wire ctrl_wr    = wr_pend_q && (wr_addr_q == PCIC_OFF_CTRL);

   assign ctrl_d    = ctrl_wr ? hwdata[6:0] : ctrl_q;
   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;
   assign hrdata    = hrdata_q;

   // read data is captured at the address phase so the data phase never waits
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         ctrl_q    <= PCIC_CTRL_RESET;
         wr_pend_q <= 1'b0;
         wr_addr_q <= 8'h00;
         hrdata_q  <= 32'h0000_0000;
      end else begin
         ctrl_q    <= ctrl_d;
         wr_pend_q <= wr_take;
         wr_addr_q <= wr_take ? haddr[7:0] : wr_addr_q;
         hrdata_q  <= rd_take ? rd_mux : hrdata_q;
      end
   end

   // ------------------------------------------------------------
   // configuration decode
   // ------------------------------------------------------------
   pcic_speed_t spd_sel;
   wire         admin_en = ctrl_q[PCIC_CTRL_EN];
   wire [1:0]   dpx_sel  = ctrl_q[PCIC_CTRL_DPX_LO +: 2];
   wire         fc_cfg   = ctrl_q[PCIC_CTRL_FC];

   assign spd_sel = pcic_speed_t'(ctrl_q[PCIC_CTRL_SPD_LO +: 3]);

   function automatic logic spd_is_auto(input pcic_speed_t s);
      spd_is_auto = (s == PCIC_SPD_AUTO) || (s == PCIC_SPD_AUTO_10) ||
                    (s == PCIC_SPD_AUTO_100) || (s == PCIC_SPD_AUTO_1000) ||
                    (s == negotiate_low_two_rates);
   endfunction

   logic       adv10;
   logic       adv100;
   logic       adv1000;
   logic [1:0] frate;

   always_comb begin
      adv10   = 1'b0;
      adv100  = 1'b0;
      adv1000 = 1'b0;
      frate   = PCIC_RATE_10;
      unique case (spd_sel)
         PCIC_SPD_AUTO: begin
            adv10   = 1'b1;
            adv100  = 1'b1;
            adv1000 = 1'b1;
         end
         PCIC_SPD_AUTO_10:        adv10 = 1'b1;
         PCIC_SPD_AUTO_100:       adv100 = 1'b1;
         PCIC_SPD_AUTO_1000:      adv1000 = 1'b1;
         negotiate_low_two_rates: begin
            adv10  = 1'b1;
            adv100 = 1'b1;
         end
         PCIC_SPD_FORCE_10:   frate = PCIC_RATE_10;
         PCIC_SPD_FORCE_100:  frate = PCIC_RATE_100;
         PCIC_SPD_FORCE_1000: frate = PCIC_RATE_1000;
      endcase
   end

   wire auto_spd = spd_is_auto(spd_sel);
   wire adv_half = (dpx_sel != PCIC_DPX_FULL);
   wire adv_full = (dpx_sel != PCIC_DPX_HALF);
   // forced speed with auto duplex defaults to full
   wire frc_full = (dpx_sel != PCIC_DPX_HALF);

   // ------------------------------------------------------------
   // pause resolution
   // ------------------------------------------------------------
   logic an_done_d1_q;
   logic an_rxp_q;
   logic an_txp_q;
   logic an_ok_q;
   wire  an_rise = an_done && !an_done_d1_q;

   // latch pause outcome of last negotiation
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         an_done_d1_q <= 1'b0;
         an_rxp_q     <= 1'b0;
         an_txp_q     <= 1'b0;
         an_ok_q      <= 1'b0;
      end else begin
         an_done_d1_q <= an_done;
         an_ok_q      <= an_rise ? 1'b1 : (an_ok_q && an_done);
         an_rxp_q     <= an_rise ? (fc_cfg && lp_pause && lp_full) : an_rxp_q;
         an_txp_q     <= an_rise ? (fc_cfg && lp_pause && lp_full) : an_txp_q;
      end
   end

   wire rxp_d = !admin_en ? 1'b0 : (auto_spd ? an_rxp_q : fc_cfg);
   wire txp_d = !admin_en ? 1'b0 : (auto_spd ? an_txp_q : fc_cfg);
   wire [1:0] rate_now = auto_spd ? lp_rate : frate;
   wire       full_now = (auto_spd || dpx_sel == PCIC_DPX_AUTO) ? lp_full : frc_full;

   // ------------------------------------------------------------
   // phy and mac control outputs
   // ------------------------------------------------------------
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         phy_enable      <= 1'b0;
         phy_an_enable   <= 1'b0;
         phy_adv_10      <= 1'b0;
         phy_adv_100     <= 1'b0;
         phy_adv_1000    <= 1'b0;
         phy_adv_half    <= 1'b0;
         phy_adv_full    <= 1'b0;
         phy_adv_pause   <= 1'b0;
         phy_force_rate  <= PCIC_RATE_10;
         phy_force_full  <= 1'b0;
         mac_rx_pause_en <= 1'b0;
         mac_tx_pause_en <= 1'b0;
      end else begin
         phy_enable      <= admin_en;
         phy_an_enable   <= auto_spd;
         phy_adv_10      <= adv10;
         phy_adv_100     <= adv100;
         phy_adv_1000    <= adv1000;
         phy_adv_half    <= adv_half;
         phy_adv_full    <= adv_full;
         phy_adv_pause   <= auto_spd && fc_cfg;
         phy_force_rate  <= frate;
         phy_force_full  <= frc_full;
         mac_rx_pause_en <= rxp_d && link_up;
         mac_tx_pause_en <= txp_d && link_up;
      end
   end

   // ------------------------------------------------------------
   // interface counters
   // ------------------------------------------------------------
   logic [CNT_W-1:0] cnt_q [PCIC_NUM_CNT];
   logic [PCIC_NUM_CNT-1:0] cnt_ev;
   logic [CNT_W-1:0]        cnt_amt [PCIC_NUM_CNT];

   // octet events carry the framed length
   assign cnt_ev[PCIC_C_RX_OCT]   = rx_frame_ev;
   assign cnt_ev[PCIC_C_TX_OCT]   = tx_frame_ev;
   assign cnt_ev[PCIC_C_RX_UCAST] = rx_ucast_ev;
   assign cnt_ev[PCIC_C_RX_UNK]   = rx_unknown_ev;
   assign cnt_ev[PCIC_C_RX_DISC]  = rx_discard_ev;
   assign cnt_ev[PCIC_C_TX_UCAST] = tx_ucast_req;
   assign cnt_ev[PCIC_C_TX_UNK]   = tx_unknown_req;
   assign cnt_ev[PCIC_C_TX_DISC]  = tx_discard_ev;
   assign cnt_ev[PCIC_C_RX_MCAST] = rx_mcast_ev;
   assign cnt_ev[PCIC_C_RX_BCAST] = rx_bcast_ev;
   assign cnt_ev[PCIC_C_TX_MCAST] = tx_mcast_req;
   assign cnt_ev[PCIC_C_TX_BCAST] = tx_bcast_req;

   genvar gc;
   generate
      for (gc = 0; gc < PCIC_NUM_CNT; gc++) begin : g_cnt
         if (gc == PCIC_C_RX_OCT) begin : g_rxo
            assign cnt_amt[gc] = CNT_W'(rx_frame_octets);
         end else if (gc == PCIC_C_TX_OCT) begin : g_txo
            assign cnt_amt[gc] = CNT_W'(tx_frame_octets);
         end else begin : g_one
            assign cnt_amt[gc] = CNT_W'(1);
         end
         always_ff @(posedge clock or negedge reset_n) begin
            if (!reset_n) begin
               cnt_q[gc] <= '0;
            end else if (cnt_ev[gc]) begin
               cnt_q[gc] <= CNT_W'(cnt_q[gc] + cnt_amt[gc]);
            end
         end
      end
   endgenerate

   // ------------------------------------------------------------
   // read mux
   // ------------------------------------------------------------
   logic [31:0] status_w;
   logic [7:0]  cnt_off;
   logic [3:0]  cnt_idx;
   wire  [7:0]  rd_addr = haddr[7:0];

   always_comb begin
      status_w = 32'h0000_0000;
      status_w[PCIC_ST_EN]          = admin_en;
      status_w[PCIC_ST_LINK]        = admin_en && link_up;
      status_w[PCIC_ST_SPD_LO +: 2] = rate_now;
      status_w[PCIC_ST_FULL]        = full_now;
      status_w[PCIC_ST_RXP]         = rxp_d;
      status_w[PCIC_ST_TXP]         = txp_d;
      status_w[PCIC_ST_FC_CFG]      = fc_cfg;
      status_w[PCIC_ST_AN_OK]       = an_ok_q;
   end

   assign cnt_off = 8'(rd_addr - PCIC_OFF_CNT0);
   assign cnt_idx = cnt_off[5:2];

   wire in_cnt = (rd_addr >= PCIC_OFF_CNT0) && (cnt_idx < 4'(PCIC_NUM_CNT)) &&
                 (cnt_off[7:6] == 2'h0) && (rd_addr[1:0] == 2'h0);

   // unmapped addresses read as zero and writes to them are dropped
   always_comb begin
      rd_mux = 32'h0000_0000;
      if (rd_addr == PCIC_OFF_CTRL) begin
         rd_mux = {25'h0, ctrl_q};
      end else if (rd_addr == PCIC_OFF_STATUS) begin
         rd_mux = status_w;
      end else if (in_cnt) begin
         rd_mux = 32'(cnt_q[cnt_idx]);
      end
   end

endmodule

`default_nettype wire

/* pcic_pkg.sv */
// pcic_pkg: register map, field layout, modes and reset values of the port control block
package pcic_pkg;

   // ------------------------------------------------------------
   // register byte offsets
   // ------------------------------------------------------------
   localparam logic [7:0] PCIC_OFF_CTRL   = 8'h00;
   localparam logic [7:0] PCIC_OFF_STATUS = 8'h04;
   localparam logic [7:0] PCIC_OFF_CNT0   = 8'h10;
   localparam int         PCIC_NUM_CNT    = 12;

   // counter slots, offset = PCIC_OFF_CNT0 + 4 * index
   localparam int PCIC_C_RX_OCT   = 0;
   localparam int PCIC_C_RX_UCAST = 1;
   localparam int PCIC_C_RX_UNK   = 2;
   localparam int PCIC_C_RX_DISC  = 3;
   localparam int PCIC_C_TX_OCT   = 4;
   localparam int PCIC_C_TX_UCAST = 5;
   localparam int PCIC_C_TX_UNK   = 6;
   localparam int PCIC_C_TX_DISC  = 7;
   localparam int PCIC_C_RX_MCAST = 8;
   localparam int PCIC_C_RX_BCAST = 9;
   localparam int PCIC_C_TX_MCAST = 10;
   localparam int PCIC_C_TX_BCAST = 11;

   // ------------------------------------------------------------
   // control register fields
   // ------------------------------------------------------------
   localparam int PCIC_CTRL_EN     = 0;
   localparam int PCIC_CTRL_SPD_LO = 1;
   localparam int PCIC_CTRL_DPX_LO = 4;
   localparam int PCIC_CTRL_FC     = 6;
   localparam logic [6:0] PCIC_CTRL_RESET = 7'h00;

   // ------------------------------------------------------------
   // status register fields
   // ------------------------------------------------------------
   localparam int PCIC_ST_EN     = 0;
   localparam int PCIC_ST_LINK   = 1;
   localparam int PCIC_ST_SPD_LO = 2;
   localparam int PCIC_ST_FULL   = 4;
   localparam int PCIC_ST_RXP    = 5;
   localparam int PCIC_ST_TXP    = 6;
   localparam int PCIC_ST_FC_CFG = 7;
   localparam int PCIC_ST_AN_OK  = 8;

   // speed selection codes
   typedef enum logic [2:0] {
      PCIC_SPD_AUTO      = 3'h0,
      PCIC_SPD_AUTO_10   = 3'h1,
      PCIC_SPD_AUTO_100  = 3'h2,
      PCIC_SPD_AUTO_1000 = 3'h3,
      negotiate_low_two_rates = 3'h4,
      PCIC_SPD_FORCE_10  = 3'h5,
      PCIC_SPD_FORCE_100 = 3'h6,
      PCIC_SPD_FORCE_1000 = 3'h7
   } pcic_speed_t;

   // duplex selection codes
   localparam logic [1:0] PCIC_DPX_AUTO = 2'h0;
   localparam logic [1:0] PCIC_DPX_FULL = 2'h1;
   localparam logic [1:0] PCIC_DPX_HALF = 2'h2;

   // line rate encoding
   localparam logic [1:0] PCIC_RATE_10   = 2'h0;
   localparam logic [1:0] PCIC_RATE_100  = 2'h1;
   localparam logic [1:0] PCIC_RATE_1000 = 2'h2;

   // ahb transfer type
   localparam logic [1:0] PCIC_HTRANS_NONSEQ = 2'h2;

endpackage

/* pcic_port_chk.sv */
// pcic_port_chk: port-level assertions for pcic_port
`timescale 1ns/1ps
`default_nettype none
module pcic_port_chk
   import pcic_pkg::*;
(
   input wire logic        clock,
   input wire logic        reset_n,
   input wire logic        hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0]  htrans,
   input wire logic        hwrite,
   input wire logic        hready,
   input wire logic [31:0] hwdata,
   input wire logic [31:0] hrdata,
   input wire logic        hreadyout,
   input wire logic        hresp,
   input wire logic        phy_enable,
   input wire logic        phy_an_enable,
   input wire logic        phy_adv_10,
   input wire logic        phy_adv_100,
   input wire logic        phy_adv_1000,
   input wire logic        phy_adv_half,
   input wire logic        phy_adv_full,
   input wire logic        phy_adv_pause,
   input wire logic [1:0]  phy_force_rate,
   input wire logic        phy_force_full,
   input wire logic        mac_rx_pause_en,
   input wire logic        mac_tx_pause_en
);
   // ------------------------------------------------------------
   // shadow of the control word, taken where the slave takes write data
   // ------------------------------------------------------------
   logic            wp_q;
   logic [6:0]      sh_q;
   wire logic       take  = hsel && hready && (htrans == PCIC_HTRANS_NONSEQ);
   wire logic       rtake = take && !hwrite;
   wire logic [2:0] spd   = sh_q[3:1];
   wire logic [1:0] dpx   = sh_q[5:4];
   wire logic       spd_auto = spd < 3'h5;
   wire logic [2:0] adv   = (spd == 3'h0) ? 3'h7 : (spd == 3'h1) ? 3'h4 :
                            (spd == 3'h2) ? 3'h2 : (spd == 3'h3) ? 3'h1 : 3'h6;
   wire logic [1:0] dadv  = (dpx == 2'h1) ? 2'h1 : (dpx == 2'h2) ? 2'h2 : 2'h3;
   wire logic [1:0] frate = spd[1:0] - 2'h1;
   wire logic       fdpx  = dpx != 2'h2;

   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         wp_q <= 1'b0;
         sh_q <= PCIC_CTRL_RESET;
      end else begin
         wp_q <= take && hwrite && (haddr[7:0] == PCIC_OFF_CTRL);
         if (wp_q) begin
            sh_q <= hwdata[6:0];
         end
      end
   end

   // ------------------------------------------------------------
   // properties; outputs follow the control word one edge after it lands
   // ------------------------------------------------------------
   default clocking cb @(posedge clock); endclocking
   default disable iff (!reset_n);

   a_bus_okay:
      assert property (hreadyout && !hresp) else $error("bus answer not ready or not okay");
   a_admin_follow:
      assert property (phy_enable == $past(sh_q[0])) else $error("port enable wrong");
   a_auto_select:
      assert property (phy_enable |-> phy_an_enable == $past(spd_auto))
         else $error("negotiation enable wrong");
   a_adv_rates:
      assert property (phy_enable && phy_an_enable |->
         {phy_adv_10, phy_adv_100, phy_adv_1000} == $past(adv)) else $error("rates wrong");
   a_adv_duplex:
      assert property (phy_enable && phy_an_enable |-> {phy_adv_half, phy_adv_full} == $past(dadv))
         else $error("advertised duplex wrong");
   a_adv_pause:
      assert property (phy_enable && phy_an_enable |-> phy_adv_pause == $past(sh_q[6]))
         else $error("advertised pause wrong");
   a_force_mode:
      assert property (phy_enable && !phy_an_enable |->
         phy_force_rate == $past(frate) && phy_force_full == $past(fdpx))
         else $error("forced rate or duplex wrong");
   a_pause_off:
      assert property (!phy_enable && !$past(phy_enable) |-> !mac_rx_pause_en && !mac_tx_pause_en)
         else $error("pause on while port down");
   a_pause_pair:
      assert property (mac_rx_pause_en == mac_tx_pause_en) else $error("pause halves differ");
   a_fixed_fc:
      assert property (mac_rx_pause_en && !phy_an_enable |-> $past(sh_q[6]))
         else $error("forced pause without flow control");
   a_rdata_hold:
      assert property (!$past(rtake) |-> $stable(hrdata)) else $error("read data moved");

   c_ctrl_write:  cover property (wp_q);
   c_auto_pause:  cover property (mac_rx_pause_en && phy_an_enable);
   c_forced_up:   cover property (phy_enable && !phy_an_enable && mac_tx_pause_en);
endmodule

bind pcic_port pcic_port_chk u_chk (.clock(clock), .reset_n(reset_n), .hsel(hsel),
   .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hready(hready), .hwdata(hwdata),
   .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .phy_enable(phy_enable),
   .phy_an_enable(phy_an_enable), .phy_adv_10(phy_adv_10), .phy_adv_100(phy_adv_100),
   .phy_adv_1000(phy_adv_1000), .phy_adv_half(phy_adv_half), .phy_adv_full(phy_adv_full),
   .phy_adv_pause(phy_adv_pause), .phy_force_rate(phy_force_rate),
   .phy_force_full(phy_force_full), .mac_rx_pause_en(mac_rx_pause_en),
   .mac_tx_pause_en(mac_tx_pause_en));
`default_nettype wire

/* pcic_phy_model.sv */
// pcic_phy_model: behavioural link partner on the phy pins of pcic_port
`timescale 1ns/1ps
`default_nettype none
module pcic_phy_model (
   input  wire logic       clock,
   input  wire logic       reset_n,
   input  wire logic       lp_pause_cap,
   input  wire logic       phy_enable,
   input  wire logic       phy_an_enable,
   input  wire logic       phy_adv_100,
   input  wire logic       phy_adv_1000,
   input  wire logic       phy_adv_full,
   input  wire logic [1:0] phy_force_rate,
   input  wire logic       phy_force_full,
   output logic            phy_link_up,
   output logic            phy_an_done,
   output logic            phy_lp_pause,
   output logic [1:0]      phy_rate,
   output logic            phy_full
);
   // ------------------------------------------------------------
   // training: any change of the local setup other than the 10, pause and half-duplex adverts restarts it
   // ------------------------------------------------------------
   logic [6:0]      cfg_q;
   logic [4:0]      cnt_q;
   wire logic [6:0] cfg_d = {phy_an_enable, phy_adv_100, phy_adv_1000, phy_adv_full,
                             phy_force_rate, phy_force_full};
   wire logic       up    = cnt_q > 5'h13;
   wire logic [1:0] neg_rate = phy_adv_1000 ? 2'h2 : phy_adv_100 ? 2'h1 : 2'h0;

   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         cfg_q <= 7'h00;
         cnt_q <= 5'h00;
      end else begin
         cfg_q <= cfg_d;
         if (!phy_enable || cfg_d != cfg_q) begin
            cnt_q <= 5'h00;
         end else if (!(&cnt_q)) begin
            cnt_q <= cnt_q + 5'h01;
         end
      end
   end

   // rate reads as an unused code while training, never as the old value
   assign phy_link_up  = up;
   assign phy_an_done  = up && phy_an_enable;
   assign phy_lp_pause = lp_pause_cap;
   assign phy_rate     = !up ? 2'h3 : phy_an_enable ? neg_rate : phy_force_rate;
   assign phy_full     = up && (phy_an_enable ? phy_adv_full : phy_force_full);
endmodule
`default_nettype wire

/* pcic_port_tb.sv */
// pcic_port_tb: register-level scenarios for pcic_port against a link partner model
`timescale 1ns/1ps
`default_nettype none
module pcic_port_tb;
   import pcic_pkg::*;
   logic             clock = 1'b0;
   logic             reset_n, hsel, hwrite, lp_pause, rx_fe, tx_fe;
   logic [1:0]       htrans;
   logic [2:0]       hsize;
   logic [31:0]      haddr, hwdata, rd;
   logic [7:0]       rx_oct, tx_oct;
   logic [9:0]       ev;
   wire logic [31:0] hrdata;
   wire logic        hreadyout, hresp, link, an, lpp, full, en, ane, a10, a100, a1000;
   wire logic        ah, af, ap, ffull, mrx, mtx;
   wire logic [1:0]  rate, frate;
   int               err_total, check_count;

   always #5 clock = ~clock;

   pcic_port #(.CNT_W(8), .OCT_W(8)) uut (
      .clock(clock), .reset_n(reset_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .phy_link_up(link), .phy_an_done(an),
      .phy_lp_pause(lpp), .phy_rate(rate), .phy_full(full), .phy_enable(en),
      .phy_an_enable(ane), .phy_adv_10(a10), .phy_adv_100(a100), .phy_adv_1000(a1000),
      .phy_adv_half(ah), .phy_adv_full(af), .phy_adv_pause(ap), .phy_force_rate(frate),
      .phy_force_full(ffull), .mac_rx_pause_en(mrx), .mac_tx_pause_en(mtx),
      .rx_frame_ev(rx_fe), .rx_frame_octets(rx_oct), .rx_ucast_ev(ev[0]),
      .rx_unknown_ev(ev[1]), .rx_discard_ev(ev[2]), .tx_ucast_req(ev[3]),
      .tx_unknown_req(ev[4]), .tx_discard_ev(ev[5]), .rx_mcast_ev(ev[6]), .rx_bcast_ev(ev[7]),
      .tx_mcast_req(ev[8]), .tx_bcast_req(ev[9]), .tx_frame_ev(tx_fe), .tx_frame_octets(tx_oct));

   pcic_phy_model lp (.clock(clock), .reset_n(reset_n), .lp_pause_cap(lp_pause),
      .phy_enable(en), .phy_an_enable(ane), .phy_adv_100(a100), .phy_adv_1000(a1000),
      .phy_adv_full(af), .phy_force_rate(frate), .phy_force_full(ffull), .phy_link_up(link),
      .phy_an_done(an), .phy_lp_pause(lpp), .phy_rate(rate), .phy_full(full));

   // ------------------------------------------------------------
   // bus and compare tasks
   // ------------------------------------------------------------
   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", check_count, err_total);
      if (err_total == 0 && check_count > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask

   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         err_total++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // the address phase is held until hready is seen high, then the data phase likewise
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clock);
      hsel   <= 1'b1;
      haddr  <= {24'h0, a};
      hwrite <= w;
      htrans <= PCIC_HTRANS_NONSEQ;
      do @(posedge clock); while (hreadyout !== 1'b1);
      hsel   <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge clock); while (hreadyout !== 1'b1);
      rd = hrdata;
   endtask

   task automatic chk(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m = '1);
      bus(1'b0, a, 32'h0);
      cmp(rd & m, e);
   endtask

   task automatic zeros;
      for (int i = 0; i < PCIC_NUM_CNT; i++) chk(8'(PCIC_OFF_CNT0 + 4 * i), 32'h0);
   endtask

   task automatic rst;
      @(posedge clock);
      reset_n <= 1'b0;
      repeat (6) @(posedge clock);
      reset_n <= 1'b1;
   endtask

   // restart the port each time so the partner trains afresh
   task automatic cfg(input logic [6:0] c);
      bus(1'b1, PCIC_OFF_CTRL, 32'h0);
      repeat (10) @(posedge clock);
      bus(1'b1, PCIC_OFF_CTRL, {25'h0, c});
      repeat (10) @(posedge clock);
      do bus(1'b0, PCIC_OFF_STATUS, 32'h0); while (rd[PCIC_ST_LINK] !== 1'b1);
      repeat (8) @(posedge clock);
   endtask

   function automatic logic [31:0] st(logic [1:0] r, logic f, logic p, logic c, logic a);
      return {23'h0, a, c, p, p, f, r, 2'h3};
   endfunction

   // ------------------------------------------------------------
   // scenarios
   // ------------------------------------------------------------
   initial begin
      int rt[5] = '{0, 0, 1, 2, 1};
      int ci[10] = '{1, 2, 3, 5, 6, 7, 8, 9, 10, 11};
      err_total = 0;
      check_count = 0;
      {reset_n, hsel, hwrite, rx_fe, tx_fe, htrans, haddr, hwdata, rx_oct, tx_oct, ev} = '0;
      hsize = 3'h2;
      lp_pause = 1'b1;
      rst();
      zeros();
      chk(PCIC_OFF_CTRL, 32'h0);
      chk(PCIC_OFF_STATUS, 32'hc);
      cfg(7'h41);
      chk(PCIC_OFF_STATUS, st(2'h2, 1'b1, 1'b1, 1'b1, 1'b1));
      cmp({30'h0, mrx, mtx}, 32'h3);
      lp_pause <= 1'b0;
      repeat (20) @(posedge clock);
      chk(PCIC_OFF_STATUS, st(2'h2, 1'b1, 1'b1, 1'b1, 1'b1));
      cfg(7'h41);
      chk(PCIC_OFF_STATUS, st(2'h2, 1'b1, 1'b0, 1'b1, 1'b1));
      for (int k = 1; k < 5; k++) begin
         cfg({3'h0, 3'(k), 1'b1});
         chk(PCIC_OFF_STATUS, st(2'(rt[k]), 1'b1, 1'b0, 1'b0, 1'b1));
      end
      for (int k = 5; k < 8; k++) begin
         cfg({3'h5, 3'(k), 1'b1});
         chk(PCIC_OFF_STATUS, st(2'(k - 5), 1'b1, 1'b1, 1'b1, 1'b0), 32'hff);
      end
      cfg(7'h2b);
      chk(PCIC_OFF_STATUS, st(2'h0, 1'b0, 1'b0, 1'b0, 1'b0), 32'hff);
      bus(1'b1, PCIC_OFF_CTRL, 32'h0);
      repeat (10) @(posedge clock);
      // the partner shows the unused rate code while the link is down
      chk(PCIC_OFF_STATUS, 32'hc, 32'hff);
      cmp({30'h0, mrx, mtx}, 32'h0);
      // every event counter sees a different count, several in one cycle
      for (int c = 0; c < 11; c++) begin
         @(posedge clock);
         for (int k = 0; k < 10; k++) ev[k] <= (c <= k);
         rx_fe  <= (c < 3);
         rx_oct <= (c == 2) ? 8'hff : 8'h40;
         tx_fe  <= (c < 2);
         tx_oct <= 8'h22;
      end
      chk(8'(PCIC_OFF_CNT0 + 4 * PCIC_C_RX_OCT), 32'h7f);
      chk(8'(PCIC_OFF_CNT0 + 4 * PCIC_C_TX_OCT), 32'h44);
      for (int k = 0; k < 10; k++) begin
         chk(8'(PCIC_OFF_CNT0 + 4 * ci[k]), 32'(k + 1));
      end
      @(posedge clock);
      ev[7] <= 1'b1;
      repeat (256) @(posedge clock);
      ev[7] <= 1'b0;
      chk(8'(PCIC_OFF_CNT0 + 4 * PCIC_C_RX_BCAST), 32'h8);
      bus(1'b1, 8'(PCIC_OFF_CNT0 + 4 * PCIC_C_RX_UCAST), 32'hffffffff);
      chk(8'(PCIC_OFF_CNT0 + 4 * PCIC_C_RX_UCAST), 32'h1);
      bus(1'b1, 8'h08, 32'h5a5a5a5a);
      chk(8'h08, 32'h0);
      rst();
      zeros();
      report_and_stop();
   end

   initial begin
      #100000;
      err_total++;
      report_and_stop();
   end
endmodule
`default_nettype wire
